// ---- pesh_pkg.sv ----
// Package: constants and carriers for the parameter element service handler
package pesh_pkg;

    // Unit element and variable-length data limits
    localparam logic [15:0] UNIT_TEXT_MAX    = 16'h000C;
    localparam logic [4:0]  UNIT_BYTES_MAX   = 5'h10;
    localparam logic [15:0] VAR_LEN_MAX      = 16'hFFFC;
    localparam logic [15:0] VAR_CAP_DEFAULT  = 16'h0040;
    localparam int          VAR_MEM_DEPTH    = 64;
    localparam int          VAR_AW           = 6;

    // Data status field positions
    localparam int          DS_SET_BIT       = 0;
    localparam int          DS_ENA_BIT       = 1;
    localparam int          DS_EXEC_BIT      = 2;
    localparam int          DS_ERR_BIT       = 3;
    localparam int          DS_INVALID_BIT   = 8;
    localparam logic [15:0] DS_RESET         = 16'h0000;
    localparam logic [15:0] DS_DEFINED_MASK  = 16'h010F;
    localparam logic [3:0]  DS_CMD_IDLE      = 4'h4;

    // Data type codes (attribute bits 22-20)
    localparam logic [2:0]  DT_BINARY        = 3'h0;
    localparam logic [2:0]  DT_TEXT          = 3'h4;
    localparam logic [2:0]  DT_IDN           = 3'h5;

    // Data length codes (attribute bits 18-16)
    localparam logic [2:0]  DL_TWO           = 3'h1;
    localparam logic [2:0]  DL_FOUR          = 3'h2;
    localparam logic [2:0]  DL_EIGHT         = 3'h3;

    // Service channel operations
    typedef enum logic [2:0] {
        PESH_OP_NONE,
        PESH_OP_OPEN,
        PESH_OP_RD_UNIT,
        PESH_OP_WR_UNIT,
        PESH_OP_RD_DATA,
        PESH_OP_WR_DATA
    } pesh_op_e;

    // One word of service channel traffic from the master
    typedef struct packed {
        logic        valid;
        pesh_op_e    op;
        logic        last;
        logic [15:0] word;
    } pesh_req_s;

    // One answer word towards the master
    typedef struct packed {
        logic        valid;
        logic        last;
        logic        err;
        logic [15:0] word;
    } pesh_rsp_s;

    // Attribute facts of the element served
    typedef struct packed {
        logic [2:0]  dtype;
        logic [2:0]  dlen;
        logic        proc_cmd;
    } pesh_attr_s;

    // Low byte first on the wire
    function automatic logic [15:0] pesh_swap(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction

endpackage

// ---- pesh_mem.sv ----
// Word memory holding unit text and variable-length content
`timescale 1ns/1ns
`default_nettype none
module pesh_mem (
    // Clock
    input  wire logic        mclk,
    // Write port
    input  wire logic        we,
    input  wire logic [5:0]  waddr,
    input  wire logic [15:0] wdata,
    // Read port
    input  wire logic [5:0]  raddr,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:pesh_pkg::VAR_MEM_DEPTH-1];

    // No reset: content is qualified by the stored length fields
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- pesh_limit.sv ----
// Minimum / maximum input value check for fixed-length operation data
`timescale 1ns/1ns
`default_nettype none
module pesh_limit (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Value and limits
    input  wire pesh_pkg::pesh_attr_s attr,
    input  wire logic [63:0] value,
    input  wire logic [63:0] min_val,
    input  wire logic [63:0] max_val,
    // Verdict
    output logic             ok
);
    typedef struct packed {
        logic ok;
    } pesh_lim_s;

    pesh_lim_s st_q, st_d;
    logic      signed_cmp;
    logic      has_min;
    logic      has_max;
    logic      lo_bad;
    logic      hi_bad;

    always_comb begin
        st_d       = st_q;
        signed_cmp = (attr.dtype == 3'h2);
        has_min = !(attr.dtype inside {pesh_pkg::DT_BINARY, pesh_pkg::DT_TEXT,
                                       pesh_pkg::DT_IDN});
        has_max = !(attr.dtype inside {pesh_pkg::DT_TEXT, pesh_pkg::DT_IDN});
        // Limits share length and form of the data
        lo_bad = signed_cmp ? ($signed(value) < $signed(min_val)) : (value < min_val);
        hi_bad = signed_cmp ? ($signed(value) > $signed(max_val)) : (value > max_val);
        // Binary data: only bits set in the maximum are supported
        if (attr.dtype == pesh_pkg::DT_BINARY) begin
            hi_bad = |(value & ~max_val);
        end
        st_d.ok = !(has_min && lo_bad) && !(has_max && hi_bad);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ok = st_q.ok;
endmodule
`default_nettype wire

// ---- pesh_top.sv ----
// Drive-side service channel handler for unit, limits, data and data status
// Operation
// - Unit element is at most 16 bytes: two lengths, text of 12 chars.
// - First length word is programmed length, second is drive capacity.
// - Unit text longer than reported capacity is never stored.
// - Binary-number and text data have no unit element.
// - Empty content transfers only the two length words, programmed length zero.
// - Written capacity word is ignored; reads return the drive's own capacity.
// - Written value below minimum leaves stored data unchanged.
// - Written value above maximum leaves stored data unchanged.
// - No minimum for binary, text, identifier; no maximum for text, identifier.
// - Binary maximum has exactly the supported bits set.
// - Limits have the same length and display form as the data.
// - Data is fixed 2, 4 or 8 bytes, or variable up to 65532.
// - Variable data starts with four length bytes; lengths 1..0xFFFC or empty.
// - Length words travel low byte first.
// - Opening the channel returns the current data status.
// - Reinit clears acknowledgement; bits 0-3 only for procedure commands.
// - Executed bit falling or error bit rising flags a command change.
// - Bit 8 set when the data block is judged invalid.
// - Status encoding: set, enabled, executed-low, error; other bits reserved.
`timescale 1ns/1ns
`default_nettype none
module pesh_top (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Service channel from the master
    input  wire pesh_pkg::pesh_req_s  req,
    // Service channel answer
    output pesh_pkg::pesh_rsp_s       rsp,
    // Element description
    input  wire pesh_pkg::pesh_attr_s attr,
    input  wire logic [63:0]          min_val,
    input  wire logic [63:0]          max_val,
    // Procedure command state from drive logic
    input  wire logic                 reinit,
    input  wire logic                 cmd_set,
    input  wire logic                 cmd_enabled,
    input  wire logic                 cmd_pending,
    input  wire logic                 cmd_error,
    input  wire logic                 checksum_err,
    // Drive status and stored data
    output logic                      cmd_change,
    output logic [15:0]               data_status,
    output logic [63:0]               fixed_data,
    output logic [15:0]               unit_len,
    output logic [15:0]               var_len
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_LEN1,
        S_LEN2,
        S_BODY,
        S_RLEN2,
        S_RBODY,
        S_RFIX
    } pesh_state_e;

    typedef logic [2:0] pesh_op_cur_t;

    typedef struct packed {
        pesh_state_e   state;
        pesh_op_cur_t  op;
        logic [15:0]   wr_len;
        logic [15:0]   cnt;
        logic          reject;
        logic [63:0]   stage;
        logic          check;
        logic [15:0]   ulen;
        logic [15:0]   vlen;
        logic [63:0]   fdata;
        logic [15:0]   status;
        logic          chg;
        pesh_pkg::pesh_rsp_s rsp;
    } pesh_top_s;

    pesh_top_s   st_q, st_d;
    logic        mem_we;
    logic [5:0]  mem_waddr;
    logic [15:0] mem_wdata;
    logic [5:0]  mem_raddr;
    logic [15:0] mem_rdata;
    logic        lim_ok;
    logic [15:0] cap;
    logic [15:0] cur_len;
    logic        is_unit;
    logic [3:0]  ds_cmd;
    logic [3:0]  fix_words;
    logic [63:0] fix_next;
    logic        unit_allowed;

    pesh_mem u_mem (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    pesh_limit u_limit (
        .mclk    (mclk),
        .rst     (rst),
        .attr    (attr),
        .value   (st_d.stage),
        .min_val (min_val),
        .max_val (max_val),
        .ok      (lim_ok)
    );

    // Words in a fixed-length element
    function automatic logic [3:0] words_of(input logic [2:0] dl);
        case (dl)
            pesh_pkg::DL_TWO:   return 4'h1;
            pesh_pkg::DL_FOUR:  return 4'h2;
            pesh_pkg::DL_EIGHT: return 4'h4;
            default:            return 4'h0;
        endcase
    endfunction

    always_comb begin
        st_d      = st_q;
        mem_we    = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        mem_raddr = '0;
        is_unit   = (st_q.op == 3'(pesh_pkg::PESH_OP_WR_UNIT)) ||
                    (st_q.op == 3'(pesh_pkg::PESH_OP_RD_UNIT));
        // Unit text capped at 12 chars; variable data capped at VAR_CAP_DEFAULT, 64 bytes
        cap       = is_unit ? pesh_pkg::UNIT_TEXT_MAX : pesh_pkg::VAR_CAP_DEFAULT;
        cur_len   = is_unit ? st_q.ulen : st_q.vlen;
        fix_words = words_of(attr.dlen);
        fix_next  = {st_q.stage[47:0], req.word};
        unit_allowed = !(attr.dtype inside {pesh_pkg::DT_BINARY, pesh_pkg::DT_TEXT});
        st_d.rsp  = '0;
        st_d.check = 1'b0;

        // Data status; command bits only for procedure commands
        ds_cmd = attr.proc_cmd ? {cmd_error, cmd_pending, cmd_enabled, cmd_set}
                               : pesh_pkg::DS_CMD_IDLE;
        if (reinit) begin
            ds_cmd = pesh_pkg::DS_CMD_IDLE;
        end
        st_d.status = 16'h0000;
        st_d.status[3:0] = attr.proc_cmd ? ds_cmd : 4'h0;
        st_d.status[pesh_pkg::DS_INVALID_BIT] = checksum_err;
        // Executed falling or error rising raises the change flag
        st_d.chg = attr.proc_cmd && !reinit &&
                   ((st_q.status[pesh_pkg::DS_EXEC_BIT] && !st_d.status[pesh_pkg::DS_EXEC_BIT]) ||
                    (!st_q.status[pesh_pkg::DS_ERR_BIT] && st_d.status[pesh_pkg::DS_ERR_BIT]));

        // Commit a checked fixed-length write one cycle after the limit verdict
        if (st_q.check && lim_ok) begin
            st_d.fdata = st_q.stage;
        end

        case (st_q.state)
            S_IDLE: begin
                st_d.cnt    = '0;
                st_d.reject = 1'b0;
                if (req.valid) begin
                    st_d.op = 3'(req.op);
                    case (req.op)
                        pesh_pkg::PESH_OP_OPEN: begin
                            st_d.rsp = '{valid: 1'b1, last: 1'b1, err: 1'b0,
                                         word: st_q.status};
                        end
                        pesh_pkg::PESH_OP_WR_UNIT, pesh_pkg::PESH_OP_WR_DATA: begin
                            if (attr.dlen inside {pesh_pkg::DL_TWO, pesh_pkg::DL_FOUR,
                                                  pesh_pkg::DL_EIGHT} &&
                                req.op == pesh_pkg::PESH_OP_WR_DATA) begin
                                st_d.stage = {48'h0, req.word};
                                st_d.cnt   = 16'h0001;
                                st_d.state = (fix_words == 4'h1) ? S_IDLE : S_BODY;
                                st_d.check = (fix_words == 4'h1);
                                st_d.rsp.valid = (fix_words == 4'h1);
                                st_d.rsp.last  = 1'b1;
                            end else begin
                                // Programmed length word, low byte first
                                st_d.wr_len = pesh_pkg::pesh_swap(req.word);
                                st_d.state  = S_LEN2;
                                st_d.reject = (req.op == pesh_pkg::PESH_OP_WR_UNIT) &&
                                              !unit_allowed;
                            end
                        end
                        pesh_pkg::PESH_OP_RD_UNIT, pesh_pkg::PESH_OP_RD_DATA: begin
                            if (req.op == pesh_pkg::PESH_OP_RD_DATA &&
                                fix_words != 4'h0) begin
                                st_d.stage = st_q.fdata;
                                st_d.state = S_RFIX;
                            end else begin
                                // First answer word: programmed length
                                st_d.rsp = '{valid: 1'b1, last: 1'b0,
                                             err: !unit_allowed &&
                                                  req.op == pesh_pkg::PESH_OP_RD_UNIT,
                                             word: pesh_pkg::pesh_swap(
                                                 req.op == pesh_pkg::PESH_OP_RD_UNIT ?
                                                 st_q.ulen : st_q.vlen)};
                                st_d.state = S_RLEN2;
                                // No unit for this type: one refusing word only
                                if (st_d.rsp.err) begin
                                    st_d.rsp.last = 1'b1;
                                    st_d.state    = S_IDLE;
                                end
                            end
                        end
                        default: begin
                            st_d.state = S_IDLE;
                        end
                    endcase
                end
            end
            S_LEN2: begin
                // Capacity word from the master is ignored
                if (req.valid) begin
                    if (st_q.wr_len > cap || st_q.wr_len > pesh_pkg::VAR_LEN_MAX) begin
                        st_d.reject = 1'b1;
                    end
                    if (st_q.wr_len == 16'h0000 || req.last) begin
                        // Empty content: only the two length words
                        st_d.state = S_IDLE;
                        st_d.rsp   = '{valid: 1'b1, last: 1'b1, err: st_d.reject,
                                       word: 16'h0000};
                        if (!st_d.reject && st_q.wr_len == 16'h0000) begin
                            if (is_unit) st_d.ulen = '0;
                            else         st_d.vlen = '0;
                        end
                    end else begin
                        st_d.state = S_BODY;
                    end
                end
            end
            S_BODY: begin
                if (req.valid) begin
                    if (fix_words != 4'h0 && st_q.op == 3'(pesh_pkg::PESH_OP_WR_DATA)) begin
                        st_d.stage = fix_next;
                        st_d.cnt   = st_q.cnt + 16'h0001;
                        if (st_d.cnt[3:0] == fix_words) begin
                            st_d.state = S_IDLE;
                            st_d.check = 1'b1;
                            st_d.rsp   = '{valid: 1'b1, last: 1'b1, err: 1'b0,
                                           word: 16'h0000};
                        end
                    end else begin
                        // Content words stored only when the write is accepted
                        mem_we    = !st_q.reject;
                        mem_waddr = is_unit ? 6'(st_q.cnt) + 6'h38 : st_q.cnt[5:0];
                        mem_wdata = req.word;
                        st_d.cnt  = st_q.cnt + 16'h0001;
                        // Whole words only: odd length rounds up a word
                        if (req.last || {st_d.cnt[14:0], 1'b0} >= st_q.wr_len) begin
                            st_d.state = S_IDLE;
                            st_d.rsp   = '{valid: 1'b1, last: 1'b1, err: st_q.reject,
                                           word: 16'h0000};
                            if (!st_q.reject) begin
                                if (is_unit) st_d.ulen = st_q.wr_len;
                                else         st_d.vlen = st_q.wr_len;
                            end
                        end
                    end
                end
            end
            S_RLEN2: begin
                // Second answer word: the drive's own capacity
                st_d.rsp   = '{valid: 1'b1, last: (cur_len == 16'h0000), err: 1'b0,
                               word: pesh_pkg::pesh_swap(cap)};
                mem_raddr  = is_unit ? 6'h38 : 6'h00;
                st_d.state = (cur_len == 16'h0000) ? S_IDLE : S_RBODY;
                st_d.cnt   = 16'h0001;
            end
            S_RBODY: begin
                st_d.rsp.valid = 1'b1;
                st_d.rsp.word  = mem_rdata;
                st_d.rsp.last  = ({st_q.cnt[14:0], 1'b0} >= cur_len);
                mem_raddr = is_unit ? 6'(st_q.cnt) + 6'h38 : st_q.cnt[5:0];
                st_d.cnt  = st_q.cnt + 16'h0001;
                if (st_d.rsp.last) begin
                    st_d.state = S_IDLE;
                end
            end
            S_RFIX: begin
                // Most significant word first for fixed data
                st_d.rsp.valid = 1'b1;
                st_d.rsp.word  = st_q.stage[16*fix_words-1 -: 16];
                st_d.cnt  = st_q.cnt + 16'h0001;
                st_d.stage = {st_q.stage[47:0], 16'h0000};
                st_d.rsp.last = (st_d.cnt[3:0] == fix_words);
                if (st_d.rsp.last) begin
                    st_d.state = S_IDLE;
                end
            end
            default: begin
                st_d.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q        <= '0;
            st_q.state  <= S_IDLE;
            st_q.status <= pesh_pkg::DS_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp         = st_q.rsp;
    assign cmd_change  = st_q.chg;
    assign data_status = st_q.status;
    assign fixed_data  = st_q.fdata;
    assign unit_len    = st_q.ulen;
    assign var_len     = st_q.vlen;
endmodule
`default_nettype wire

// ---- pesh_top_props.sv ----
// Checker for the parameter element service handler
`timescale 1ns/1ns
`default_nettype none
module pesh_top_props (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // Service channel
    input wire pesh_pkg::pesh_req_s  req,
    input wire pesh_pkg::pesh_rsp_s  rsp,
    // Element and command state
    input wire pesh_pkg::pesh_attr_s attr,
    input wire logic                 reinit,
    input wire logic                 cmd_set,
    input wire logic                 cmd_enabled,
    input wire logic                 cmd_pending,
    input wire logic                 cmd_error,
    input wire logic                 checksum_err,
    // Status and stored lengths
    input wire logic                 cmd_change,
    input wire logic [15:0]          data_status,
    input wire logic [15:0]          unit_len,
    input wire logic [15:0]          var_len
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Status is registered, so the first edge after reset still shows reset state
    a_bad_data: assert property (!$past(rst) |->
        data_status[8] == $past(checksum_err)) else $error("invalid flag wrong");
    a_reserved_zero: assert property (
        (data_status & ~pesh_pkg::DS_DEFINED_MASK) == 16'h0000) else $error("reserved set");
    a_plain_no_ack: assert property (!$past(attr.proc_cmd) |->
        data_status[3:0] == 4'h0) else $error("ack bits on plain data");
    a_ack_follows: assert property ($past(attr.proc_cmd) && !$past(rst | reinit) |->
        data_status[3:0] == $past({cmd_error, cmd_pending, cmd_enabled, cmd_set}))
        else $error("ack bits wrong");
    a_reinit_idle: assert property ($past(attr.proc_cmd && reinit) && !$past(rst) |->
        data_status[3:0] == pesh_pkg::DS_CMD_IDLE) else $error("ack not cleared");
    a_done_flags: assert property ($fell(data_status[2]) && $past(attr.proc_cmd) &&
        !reinit && !$past(reinit) |-> ##[0:1] cmd_change)
        else $error("no change flag on executed");
    a_error_flags: assert property ($rose(data_status[3]) && $past(attr.proc_cmd) &&
        !reinit && !$past(reinit) |-> ##[0:1] cmd_change)
        else $error("no change flag on error");
    a_var_cap: assert property (var_len <= pesh_pkg::VAR_CAP_DEFAULT)
        else $error("variable length above capacity");
    a_unit_cap: assert property (unit_len <= pesh_pkg::UNIT_TEXT_MAX)
        else $error("unit length above capacity");
    c_change: cover property (cmd_change);
    c_refused: cover property (rsp.valid && rsp.err);
    c_open: cover property (req.valid && req.op == pesh_pkg::PESH_OP_OPEN);
endmodule
bind pesh_top pesh_top_props u_props (
    .mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .attr(attr), .reinit(reinit),
    .cmd_set(cmd_set), .cmd_enabled(cmd_enabled), .cmd_pending(cmd_pending),
    .cmd_error(cmd_error), .checksum_err(checksum_err), .cmd_change(cmd_change),
    .data_status(data_status), .unit_len(unit_len), .var_len(var_len)
);
`default_nettype wire

// ---- pesh_master.sv ----
// Master control unit model driving the service channel
`timescale 1ns/1ns
`default_nettype none
module pesh_master (
    // Clock
    input  wire logic                mclk,
    // Service channel
    output var pesh_pkg::pesh_req_s  req,
    input  wire pesh_pkg::pesh_rsp_s rsp
);
    pesh_pkg::pesh_rsp_s ans [$];
    int misses = 0;
    initial req = '0;
    always @(negedge mclk) begin
        if (rsp.valid === 1'b1) begin
            ans.push_back(rsp);
        end
    end
    // Whole words only; callers pass length words low byte first
    task automatic xfer(input pesh_pkg::pesh_op_e op, input logic [15:0] w [4], input int n);
        ans.delete();
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            req <= '{1'b1, op, i == n - 1, w[i]};
        end
        @(negedge mclk);
        // A released word must not look like a held one
        req <= '{1'b0, pesh_pkg::PESH_OP_NONE, 1'b0, ~req.word};
        for (int k = 0; k < 40; k++) begin
            @(posedge mclk);
            if (ans.size() > 0 && ans[$].last === 1'b1) break;
        end
        if (ans.size() == 0 || ans[$].last !== 1'b1) misses++;
        @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- param_element_service_handler_test.sv ----
// Self-checking bench for the parameter element service handler
`timescale 1ns/1ns
`default_nettype none
module param_element_service_handler_test;
    typedef struct packed { logic p; logic [5:0] c; logic [15:0] ds; } pesh_row_s;
    typedef struct packed { logic [2:0] dt; logic [15:0] v; logic [15:0] e; } pesh_fx_s;
    // Status inputs packed as {reinit, error, pending, enabled, set, checksum}
    localparam pesh_row_s ROWS [6] = '{'{1'b1, 6'h1F, 16'h010F}, '{1'b1, 6'h0A, 16'h0005},
        '{1'b1, 6'h04, 16'h0002}, '{1'b0, 6'h1F, 16'h0100}, '{1'b1, 6'h31, 16'h0104},
        '{1'b1, 6'h10, 16'h0008}};
    localparam logic [5:0] CHG [3] = '{6'h00, 6'h10, 6'h18};
    localparam logic [15:0] CHG_N [3] = '{16'h0001, 16'h0001, 16'h0000};
    localparam logic [15:0] RD [4] = '{16'h0400, 16'h4000, 16'hA1B2, 16'hC3D4};
    localparam pesh_fx_s FX [5] = '{'{3'h2, 16'h0050, 16'h0050}, '{3'h2, 16'h0005, 16'h0050},
        '{3'h2, 16'h0200, 16'h0050}, '{3'h2, 16'h0100, 16'h0100}, '{3'h0, 16'h0003, 16'h0003}};
    logic                 mclk = 1'b0;
    logic                 rst = 1'b1;
    logic [5:0]           cin = 6'h00;
    logic [63:0]          min_val = 64'h0000000000000010;
    logic [63:0]          max_val = 64'h0000000000000100;
    pesh_pkg::pesh_attr_s attr = '0;
    pesh_pkg::pesh_req_s  req;
    pesh_pkg::pesh_rsp_s  rsp;
    logic                 cmd_change;
    logic [15:0]          data_status;
    logic [63:0]          fixed_data;
    logic [15:0]          unit_len;
    logic [15:0]          var_len;
    logic [15:0]          n;
    int                   err_total = 0;
    int                   compares = 0;
    always #4 mclk = ~mclk;
    pesh_top u_dut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .attr(attr),
        .min_val(min_val), .max_val(max_val), .reinit(cin[5]), .cmd_set(cin[1]),
        .cmd_enabled(cin[2]), .cmd_pending(cin[3]), .cmd_error(cin[4]),
        .checksum_err(cin[0]), .cmd_change(cmd_change), .data_status(data_status),
        .fixed_data(fixed_data), .unit_len(unit_len), .var_len(var_len));
    pesh_master u_mst (.mclk(mclk), .req(req), .rsp(rsp));
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic report_and_stop();
        err_total += u_mst.misses;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run is about 120 cycles; the 12500-cycle limit leaves ample margin
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
    initial begin
        tick(10);
        chk16("status in reset", pesh_pkg::DS_RESET, data_status);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            attr.proc_cmd <= ROWS[i].p;
            cin <= ROWS[i].c;
            tick(2);
            chk16("data_status", ROWS[i].ds, data_status);
        end
        cin <= 6'h08;
        tick(3);
        foreach (CHG[j]) begin
            cin <= CHG[j];
            n = 16'h0000;
            repeat (4) begin
                @(negedge mclk);
                if (cmd_change === 1'b1) n++;
            end
            chk16("change pulses", CHG_N[j], n);
        end
        cin <= 6'h0B;
        tick(2);
        u_mst.xfer(pesh_pkg::PESH_OP_OPEN, '{16'h0000, 16'h0, 16'h0, 16'h0}, 1);
        chk16("open status", 16'h0105, u_mst.ans[0].word);
        cin <= 6'h00;
        attr <= '{3'h1, 3'h4, 1'b0};
        // Capacity word sent is junk on purpose; it must be ignored
        u_mst.xfer(pesh_pkg::PESH_OP_WR_DATA, '{16'h0400, 16'hFFFF, 16'hA1B2, 16'hC3D4}, 4);
        chk16("var write err", 16'h0000, 16'(u_mst.ans[$].err));
        chk16("var_len", 16'h0004, var_len);
        u_mst.xfer(pesh_pkg::PESH_OP_RD_DATA, '{16'h0000, 16'h0, 16'h0, 16'h0}, 1);
        foreach (RD[i]) chk16("var read", RD[i], u_mst.ans[i].word);
        u_mst.xfer(pesh_pkg::PESH_OP_WR_DATA, '{16'h4200, 16'h0000, 16'h1111, 16'h0}, 3);
        chk16("oversize err", 16'h0001, 16'(u_mst.ans[$].err));
        chk16("var_len kept", 16'h0004, var_len);
        u_mst.xfer(pesh_pkg::PESH_OP_WR_DATA, '{16'h0000, 16'h4000, 16'h0, 16'h0}, 2);
        chk16("empty var_len", 16'h0000, var_len);
        u_mst.xfer(pesh_pkg::PESH_OP_RD_DATA, '{16'h0000, 16'h0, 16'h0, 16'h0}, 1);
        chk16("empty count", 16'h0002, 16'(u_mst.ans.size()));
        chk16("empty length", 16'h0000, u_mst.ans[0].word);
        u_mst.xfer(pesh_pkg::PESH_OP_WR_UNIT, '{16'h0200, 16'h0000, 16'h4D4D, 16'h0}, 3);
        chk16("unit_len", 16'h0002, unit_len);
        u_mst.xfer(pesh_pkg::PESH_OP_WR_UNIT, '{16'h0E00, 16'h0000, 16'h4141, 16'h0}, 3);
        chk16("unit too long", 16'h0001, 16'(u_mst.ans[$].err));
        chk16("unit_len kept", 16'h0002, unit_len);
        attr.dtype <= pesh_pkg::DT_BINARY;
        u_mst.xfer(pesh_pkg::PESH_OP_RD_UNIT, '{16'h0000, 16'h0, 16'h0, 16'h0}, 1);
        chk16("binary unit err", 16'h0001, 16'(u_mst.ans[$].err));
        attr.dlen <= pesh_pkg::DL_TWO;
        foreach (FX[i]) begin
            attr.dtype <= FX[i].dt;
            max_val <= (FX[i].dt == pesh_pkg::DT_BINARY) ? 64'h00000000000000FF : 64'h100;
            u_mst.xfer(pesh_pkg::PESH_OP_WR_DATA, '{FX[i].v, 16'h0, 16'h0, 16'h0}, 1);
            tick(3);
            chk16("fixed_data", FX[i].e, fixed_data[15:0]);
        end
        u_mst.xfer(pesh_pkg::PESH_OP_RD_DATA, '{16'h0000, 16'h0, 16'h0, 16'h0}, 1);
        chk16("fixed read", 16'h0003, u_mst.ans[0].word);
        cin <= 6'h1F;
        rst <= 1'b1;
        tick(2);
        chk16("status mid reset", pesh_pkg::DS_RESET, data_status);
        rst <= 1'b0;
        tick(3);
        chk16("status after reset", 16'h0100, data_status);
        report_and_stop();
    end
endmodule
`default_nettype wire
